// [address_arith_slice_consts.svh]
`ifndef ADDRESS_ARITH_SLICE_CONSTS_SVH
`define ADDRESS_ARITH_SLICE_CONSTS_SVH

// ----------------------------------------------------------------
// slice geometry
// ----------------------------------------------------------------
`define SLICE_W 4
`define SLICE_MSB 3
`define OP_SHOW_SUM_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define REG_RST_VAL 4'h0
`define OUT_N_RST_VAL 4'hf

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define OP_PC_ADD_SHOW_PC 4'h0
`define OP_PC_ADD_SHOW_SUM 4'h1
`define OP_PC_TO_SP_SHOW_PC 4'h2
`define OP_PC_TO_SP_SHOW_SUM 4'h3
`define OP_SHOW_PC_A 4'h4
`define OP_PC_TO_OA 4'h5
`define OP_SHOW_SP_A 4'h6
`define OP_SP_ADD 4'h7
`define OP_SHOW_OA_A 4'h8
`define OP_LOAD_OA 4'h9
`define OP_SHOW_PC_B 4'ha
`define OP_LOAD_PC 4'hb
`define OP_SHOW_OA_B 4'hc
`define OP_OA_ADD 4'hd
`define OP_SHOW_SP_B 4'he
`define OP_LOAD_SP 4'hf

`endif

// [address_arith_slice_pkg.sv]
`include "address_arith_slice_consts.svh"

package address_arith_slice_pkg;

  typedef logic [`SLICE_MSB:0] nibble_t;

  typedef enum logic [1:0] {
    sel_none,
    sel_pc,
    sel_sp,
    sel_oa
  } reg_sel_t;

  typedef struct packed {
    reg_sel_t src;
    reg_sel_t dst;
    logic show_sum;
  } op_decode_t;

  typedef struct packed {
    nibble_t pc;
    nibble_t sp;
    nibble_t oa;
    nibble_t out_n;
  } slice_state_t;

endpackage

// [slice_adder.sv]
`timescale 1ns/10ps
`include "address_arith_slice_consts.svh"

// ----------------------------------------------------------------
// 4-bit adder with carry in and out, active high internally
// ----------------------------------------------------------------
module slice_adder (
  input wire logic [`SLICE_MSB:0] a_i,
  input wire logic [`SLICE_MSB:0] b_i,
  input wire logic cin_i,
  output logic [`SLICE_MSB:0] sum_o,
  output logic cout_o
);

  logic [`SLICE_W:0] full;

  always_comb begin
    full = {1'b0, a_i} + {1'b0, b_i} + {{`SLICE_W{1'b0}}, cin_i};
    sum_o = full[`SLICE_MSB:0];
    cout_o = full[`SLICE_W];
  end

endmodule

// [address_arith_slice.sv]
`timescale 1ns/10ps
`include "address_arith_slice_consts.svh"

// How it works
// - three registers plus separate output register
// - inverted data and carry feed adder
// - bits one to three pick operand, except codes 9,11,15 pick none
// - commit sum on edge when gate low
// - inputs set up before committing edge
// - bit zero high shows sum on bus
// - bit zero low shows selected register
// - address bus driven only when enabled
// - result pins show output register when enabled
// - slices chain through active-low ripple carry
// - codes 0,1 update program counter
// - codes 2,3 load stack pointer from pc
// - code 5 loads operand address from pc
// - code 7 steps stack pointer
// - code 13 steps operand address
// - codes 9,11,15 load data plus carry
// - even codes 4..14 only show register
module address_arith_slice (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [`SLICE_MSB:0] op_select_i,
  input wire logic [`SLICE_MSB:0] operand_in_n_i,
  input wire logic carry_in_n_i,
  input wire logic run_gate_n_i,
  input wire logic addr_drive_en_n_i,
  input wire logic result_drive_en_n_i,
  output logic [`SLICE_MSB:0] addr_bus_o,
  output logic addr_bus_oe_o,
  output logic [`SLICE_MSB:0] result_out_n_o,
  output logic result_out_n_oe_o,
  output logic carry_out_n_o
);

  // ----------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------
  function automatic address_arith_slice_pkg::op_decode_t decode_op(
    input logic [`SLICE_MSB:0] op
  );
    address_arith_slice_pkg::op_decode_t dec;
    dec.show_sum = op[`OP_SHOW_SUM_BIT];
    dec.src = address_arith_slice_pkg::sel_none;
    dec.dst = address_arith_slice_pkg::sel_none;
    unique case (op)
      `OP_PC_ADD_SHOW_PC, `OP_PC_ADD_SHOW_SUM: begin
        dec.src = address_arith_slice_pkg::sel_pc;
        dec.dst = address_arith_slice_pkg::sel_pc;
      end
      `OP_PC_TO_SP_SHOW_PC, `OP_PC_TO_SP_SHOW_SUM: begin
        dec.src = address_arith_slice_pkg::sel_pc;
        dec.dst = address_arith_slice_pkg::sel_sp;
      end
      `OP_PC_TO_OA: begin
        dec.src = address_arith_slice_pkg::sel_pc;
        dec.dst = address_arith_slice_pkg::sel_oa;
      end
      `OP_SP_ADD: begin
        dec.src = address_arith_slice_pkg::sel_sp;
        dec.dst = address_arith_slice_pkg::sel_sp;
      end
      `OP_OA_ADD: begin
        dec.src = address_arith_slice_pkg::sel_oa;
        dec.dst = address_arith_slice_pkg::sel_oa;
      end
      `OP_LOAD_OA: begin
        dec.dst = address_arith_slice_pkg::sel_oa;
      end
      `OP_LOAD_PC: begin
        dec.dst = address_arith_slice_pkg::sel_pc;
      end
      `OP_LOAD_SP: begin
        dec.dst = address_arith_slice_pkg::sel_sp;
      end
      `OP_SHOW_PC_A, `OP_SHOW_PC_B: begin
        dec.src = address_arith_slice_pkg::sel_pc;
      end
      `OP_SHOW_SP_A, `OP_SHOW_SP_B: begin
        dec.src = address_arith_slice_pkg::sel_sp;
      end
      `OP_SHOW_OA_A, `OP_SHOW_OA_B: begin
        dec.src = address_arith_slice_pkg::sel_oa;
      end
    endcase
    return dec;
  endfunction

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  address_arith_slice_pkg::slice_state_t state_q;
  address_arith_slice_pkg::slice_state_t state_d;
  address_arith_slice_pkg::op_decode_t dec;
  logic [`SLICE_MSB:0] data_true;
  logic carry_true;
  logic [`SLICE_MSB:0] reg_opnd;
  logic [`SLICE_MSB:0] sum;
  logic sum_cout;
  logic commit;

  // any of sixteen codes is legal
  assign dec = decode_op(op_select_i);

  // undo active-low sense of data and carry
  assign data_true = ~operand_in_n_i;
  assign carry_true = ~carry_in_n_i;

  // register operand mux, zero when none
  always_comb begin
    unique case (dec.src)
      address_arith_slice_pkg::sel_pc: reg_opnd = state_q.pc;
      address_arith_slice_pkg::sel_sp: reg_opnd = state_q.sp;
      address_arith_slice_pkg::sel_oa: reg_opnd = state_q.oa;
      address_arith_slice_pkg::sel_none: reg_opnd = `REG_RST_VAL;
    endcase
  end

  slice_adder u_adder (
    .a_i(reg_opnd),
    .b_i(data_true),
    .cin_i(carry_true),
    .sum_o(sum),
    .cout_o(sum_cout)
  );

  // overflow past msb drives carry low
  assign carry_out_n_o = ~sum_cout;

  // inputs sampled only at committing edge
  assign commit = ~run_gate_n_i && (dec.dst !=
    address_arith_slice_pkg::sel_none);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // gated write into destination and output
    if (commit) begin
      state_d.out_n = ~sum;
      unique case (dec.dst)
        address_arith_slice_pkg::sel_pc: state_d.pc = sum;
        address_arith_slice_pkg::sel_sp: state_d.sp = sum;
        address_arith_slice_pkg::sel_oa: state_d.oa = sum;
        address_arith_slice_pkg::sel_none: state_d.out_n = state_q.out_n;
      endcase
    end
  end

  // pc, sp, oa and output register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q.pc <= `REG_RST_VAL;
      state_q.sp <= `REG_RST_VAL;
      state_q.oa <= `REG_RST_VAL;
      state_q.out_n <= `OUT_N_RST_VAL;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // sum or register, combinational
  // register path when bit zero low
  assign addr_bus_o = dec.show_sum ? sum : reg_opnd;

  assign addr_bus_oe_o = ~addr_drive_en_n_i;

  assign result_out_n_o = state_q.out_n;
  assign result_out_n_oe_o = ~result_drive_en_n_i;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [`SLICE_W:0] chk_full;
  assign chk_full = {1'b0, reg_opnd} + {1'b0, ~operand_in_n_i}
    + {{`SLICE_W{1'b0}}, ~carry_in_n_i};

  logic op_no_write;
  assign op_no_write = !op_select_i[`OP_SHOW_SUM_BIT] &&
    (op_select_i != `OP_PC_ADD_SHOW_PC) &&
    (op_select_i != `OP_PC_TO_SP_SHOW_PC);

  a_gate_holds_state: assert property (
    run_gate_n_i |=> $stable(state_q)
  ) else $error("state changed while gate high");

  a_out_reg_loaded: assert property (
    !run_gate_n_i && !op_no_write |=>
      result_out_n_o == ~$past(sum)
  ) else $error("output register missed committed sum");

  a_adder_operands: assert property (
    sum == chk_full[`SLICE_MSB:0]
  ) else $error("adder sum does not match inverted inputs");

  a_no_reg_operand: assert property (
    (op_select_i inside {`OP_LOAD_OA, `OP_LOAD_PC, `OP_LOAD_SP}) |->
      addr_bus_o == 4'(~operand_in_n_i + {3'h0, ~carry_in_n_i})
  ) else $error("data plus carry path wrong");

  a_bus_shows_sum: assert property (
    op_select_i[`OP_SHOW_SUM_BIT] |-> addr_bus_o == sum
  ) else $error("bus not showing sum");

  a_bus_shows_reg: assert property (
    !op_select_i[`OP_SHOW_SUM_BIT] |-> addr_bus_o == reg_opnd
  ) else $error("bus not showing register");

  a_addr_enable: assert property (
    addr_bus_oe_o == !addr_drive_en_n_i
  ) else $error("address enable wrong");

  a_result_enable: assert property (
    result_out_n_oe_o == !result_drive_en_n_i &&
    result_out_n_o == state_q.out_n
  ) else $error("result drive wrong");

  a_carry_overflow: assert property (
    carry_out_n_o == !chk_full[`SLICE_W]
  ) else $error("carry out wrong");

  a_pc_update: assert property (
    !run_gate_n_i && op_select_i[`SLICE_MSB:1] == 3'h0 |=>
      state_q.pc == $past(sum) && $stable(state_q.sp)
  ) else $error("pc update wrong");

  a_sp_from_pc: assert property (
    !run_gate_n_i && op_select_i[`SLICE_MSB:1] == 3'h1 |=>
      state_q.sp == $past(state_q.pc + ~operand_in_n_i
        + {3'h0, ~carry_in_n_i}) && $stable(state_q.pc)
  ) else $error("sp load from pc wrong");

  a_oa_from_pc: assert property (
    !run_gate_n_i && op_select_i == `OP_PC_TO_OA |=>
      state_q.oa == $past(state_q.pc + ~operand_in_n_i
        + {3'h0, ~carry_in_n_i})
  ) else $error("oa load from pc wrong");

  a_sp_step: assert property (
    !run_gate_n_i && op_select_i == `OP_SP_ADD |=>
      state_q.sp == $past(state_q.sp + ~operand_in_n_i
        + {3'h0, ~carry_in_n_i})
  ) else $error("sp step wrong");

  a_oa_step: assert property (
    !run_gate_n_i && op_select_i == `OP_OA_ADD |=>
      state_q.oa == $past(state_q.oa + ~operand_in_n_i
        + {3'h0, ~carry_in_n_i})
  ) else $error("oa step wrong");

  a_load_pc_data: assert property (
    !run_gate_n_i && op_select_i == `OP_LOAD_PC |=>
      state_q.pc == $past(4'(~operand_in_n_i + {3'h0, ~carry_in_n_i}))
  ) else $error("pc load from data wrong");

  a_load_oa_data: assert property (
    !run_gate_n_i && op_select_i == `OP_LOAD_OA |=>
      state_q.oa == $past(4'(~operand_in_n_i + {3'h0, ~carry_in_n_i}))
  ) else $error("oa load from data wrong");

  a_load_sp_data: assert property (
    !run_gate_n_i && op_select_i == `OP_LOAD_SP |=>
      state_q.sp == $past(4'(~operand_in_n_i + {3'h0, ~carry_in_n_i}))
  ) else $error("sp load from data wrong");

  a_fetch_shows_pc: assert property (
    op_select_i == `OP_PC_ADD_SHOW_PC |-> addr_bus_o == state_q.pc
  ) else $error("fetch code not showing pc");

  a_sp_load_pc: assert property (
    op_select_i == `OP_PC_TO_SP_SHOW_PC |-> addr_bus_o == state_q.pc
  ) else $error("sp load code not showing pc");

  a_show_pc_only: assert property (
    op_select_i inside {`OP_SHOW_PC_A, `OP_SHOW_PC_B} |->
      addr_bus_o == state_q.pc
  ) else $error("display code not showing pc");

  a_show_sp_only: assert property (
    op_select_i inside {`OP_SHOW_SP_A, `OP_SHOW_SP_B} |->
      addr_bus_o == state_q.sp
  ) else $error("display code not showing sp");

  a_show_oa_only: assert property (
    op_select_i inside {`OP_SHOW_OA_A, `OP_SHOW_OA_B} |->
      addr_bus_o == state_q.oa
  ) else $error("display code not showing oa");

  a_out_hold_gated: assert property (
    run_gate_n_i |=> $stable(result_out_n_o)
  ) else $error("result pins changed while gate high");

  a_ripple_carry_out: assert property (
    (op_select_i inside {`OP_LOAD_OA, `OP_LOAD_PC, `OP_LOAD_SP}) &&
    operand_in_n_i == 4'h0 && !carry_in_n_i |-> !carry_out_n_o
  ) else $error("carry out missed slice overflow");

  a_ripple_no_carry: assert property (
    op_select_i == `OP_LOAD_PC && carry_in_n_i |-> carry_out_n_o
  ) else $error("carry out without overflow");

  a_reset_values: assert property (
    disable iff (1'b0)
    !rst_n_i |=> state_q.pc == `REG_RST_VAL &&
      state_q.sp == `REG_RST_VAL && state_q.oa == `REG_RST_VAL &&
      result_out_n_o == `OUT_N_RST_VAL
  ) else $error("reset values wrong");

  a_show_no_write: assert property (
    op_no_write |=> $stable(state_q)
  ) else $error("display code wrote state");

  c_pc_fetch_inc: cover property (
    !run_gate_n_i && op_select_i == `OP_PC_ADD_SHOW_PC &&
    !carry_in_n_i ##1 !run_gate_n_i
  );

  c_carry_ripple: cover property (
    !run_gate_n_i && !carry_out_n_o && op_select_i == `OP_SP_ADD
  );

  c_gated_cycle: cover property (
    run_gate_n_i && op_select_i == `OP_LOAD_OA ##1 !run_gate_n_i
  );

  c_both_drivers: cover property (
    addr_bus_oe_o && result_out_n_oe_o && op_select_i == `OP_OA_ADD
  );

endmodule

// [ctl_model.sv]
`timescale 1ns/10ps

// ----------------------------------------------------------------
// microprogram controller model
// ----------------------------------------------------------------
module ctl_model (
  output logic [3:0] op_select_o,
  output logic [3:0] operand_in_n_o,
  output logic carry_in_n_o,
  output logic run_gate_n_o,
  output logic addr_drive_en_n_o,
  output logic result_drive_en_n_o
);
  initial begin
    addr_drive_en_n_o = 1'b1;
    result_drive_en_n_o = 1'b1;
  end

  task automatic issue(input logic [3:0] op, input logic [3:0] d,
                       input logic c, input logic g);
    op_select_o = op;
    operand_in_n_o = ~d;
    carry_in_n_o = ~c;
    run_gate_n_o = ~g;
  endtask

  // drive enables, active low at pins
  task automatic drive_en(input logic a, input logic r);
    addr_drive_en_n_o = ~a;
    result_drive_en_n_o = ~r;
  endtask
endmodule

// [address_arith_slice_tb_top.sv]
`timescale 1ns/10ps

module address_arith_slice_tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  address_arith_slice_pkg::nibble_t op_select;
  address_arith_slice_pkg::nibble_t operand_in_n;
  address_arith_slice_pkg::nibble_t addr_bus;
  address_arith_slice_pkg::nibble_t result_out_n;
  logic carry_in_n;
  logic run_gate_n;
  logic addr_drive_en_n;
  logic result_drive_en_n;
  logic addr_bus_oe;
  logic result_out_n_oe;
  logic carry_out_n;
  int failures = 0;
  int num_checks = 0;
  logic [3:0] rm [4];
  logic [3:0] out_m;
  // operand source and destination per code, 3 = none
  localparam logic [1:0] src_tab [16] = '{2'h0, 2'h0, 2'h0, 2'h0,
    2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h2, 2'h2, 2'h1, 2'h3};
  localparam logic [1:0] dst_tab [16] = '{2'h0, 2'h0, 2'h1, 2'h1,
    2'h3, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3, 2'h0, 2'h3, 2'h2, 2'h3, 2'h1};

  always #25 mclk_i = ~mclk_i;

  ctl_model ctl (
    .op_select_o(op_select),
    .operand_in_n_o(operand_in_n),
    .carry_in_n_o(carry_in_n),
    .run_gate_n_o(run_gate_n),
    .addr_drive_en_n_o(addr_drive_en_n),
    .result_drive_en_n_o(result_drive_en_n)
  );

  address_arith_slice uut (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .op_select_i(op_select),
    .operand_in_n_i(operand_in_n),
    .carry_in_n_i(carry_in_n),
    .run_gate_n_i(run_gate_n),
    .addr_drive_en_n_i(addr_drive_en_n),
    .result_drive_en_n_i(result_drive_en_n),
    .addr_bus_o(addr_bus),
    .addr_bus_oe_o(addr_bus_oe),
    .result_out_n_o(result_out_n),
    .result_out_n_oe_o(result_out_n_oe),
    .carry_out_n_o(carry_out_n)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input int n);
    ctl.issue(4'h4, 4'h0, 1'b0, 1'b0);
    rst_n_i = 1'b0;
    repeat (n) @(posedge mclk_i);
    #2;
    rst_n_i = 1'b1;
    @(posedge mclk_i);
    #2;
    for (int i = 0; i < 4; i++) rm[i] = 4'h0;
    out_m = 4'h0;
  endtask

  task automatic run_op(input logic [3:0] op, input logic [3:0] d,
                        input logic c, input logic g);
    logic [4:0] tot;
    logic [1:0] s;
    logic [1:0] t;
    s = src_tab[op];
    t = dst_tab[op];
    tot = {1'b0, rm[s]} + {1'b0, d} + {4'h0, c};
    ctl.issue(op, d, c, g);
    #5;
    chk(addr_bus, op[0] ? tot[3:0] : rm[s]);
    chk({3'h0, carry_out_n}, {3'h0, ~tot[4]});
    @(posedge mclk_i);
    #2;
    if (g && t != 2'h3) begin
      rm[t] = tot[3:0];
      out_m = tot[3:0];
    end
    chk(result_out_n, ~out_m);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    chk(result_out_n, 4'hf);
    run_op(4'h4, 4'h3, 1'b1, 1'b0);
    run_op(4'h6, 4'h3, 1'b1, 1'b0);
    run_op(4'h8, 4'h3, 1'b1, 1'b0);
  endtask

  task automatic test_all_codes();
    for (int i = 0; i < 16; i++) begin
      run_op(4'(i), 4'(i) ^ 4'h6, i[1], 1'b1);
    end
    for (int i = 15; i >= 0; i--) begin
      run_op(4'(i), 4'(i), i[0], 1'b1);
    end
  endtask

  task automatic test_gate_high();
    for (int i = 0; i < 16; i++) begin
      run_op(4'(i), 4'ha, 1'b1, 1'b0);
    end
    run_op(4'h9, 4'ha, 1'b1, 1'b0);
  endtask

  task automatic test_overflow();
    for (int i = 0; i < 16; i++) begin
      run_op(4'(i), 4'hf, 1'b1, 1'b1);
    end
  endtask

  task automatic test_enables();
    for (int i = 0; i < 4; i++) begin
      ctl.drive_en(i[0], i[1]);
      #5;
      chk({3'h0, addr_bus_oe}, {3'h0, i[0]});
      chk({3'h0, result_out_n_oe}, {3'h0, i[1]});
      @(posedge mclk_i);
      #2;
    end
  endtask

  task automatic test_midrun_reset();
    run_op(4'hb, 4'h9, 1'b0, 1'b1);
    do_reset(1);
    chk(result_out_n, 4'hf);
    run_op(4'ha, 4'h1, 1'b0, 1'b0);
  endtask

  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    do_reset(20);
    test_reset();
    test_all_codes();
    test_gate_high();
    test_overflow();
    test_enables();
    test_midrun_reset();
    test_all_codes();
    report_and_stop();
  end

  initial begin
    repeat (3000) @(posedge mclk_i);
    failures++;
    report_and_stop();
  end
endmodule
